// ---- inc/cmpe_pkg.sv ----
// package for the comparator event control block
package cmpe_pkg;
    localparam int CMPE_N = 3;
    localparam int CMPE_AW = 4;
    localparam int CMPE_DW = 16;
    // register offsets
    localparam logic [3:0] CMPE_OFF_CTRL0 = 4'h0;
    localparam logic [3:0] CMPE_OFF_CTRL1 = 4'h1;
    localparam logic [3:0] CMPE_OFF_CTRL2 = 4'h2;
    localparam logic [3:0] CMPE_OFF_STAT = 4'h3;
    localparam logic [3:0] CMPE_OFF_IRQ_STAT = 4'h4;
    localparam logic [3:0] CMPE_OFF_IRQ_MASK = 4'h5;
    // control field positions
    localparam int CMPE_B_ON = 15;
    localparam int CMPE_B_TOPIN = 14;
    localparam int CMPE_B_INV = 13;
    localparam int CMPE_B_EVT = 9;
    localparam int CMPE_B_RES = 8;
    localparam int CMPE_B_EDGE_HI = 7;
    localparam int CMPE_B_EDGE_LO = 6;
    localparam int CMPE_B_REF = 4;
    localparam int CMPE_B_CH_HI = 1;
    localparam int CMPE_B_CH_LO = 0;
    // shared status positions: events at 8+n, results at n
    localparam int CMPE_B_STAT_EVT = 8;
    localparam int CMPE_B_STAT_RES = 0;
    localparam logic [15:0] CMPE_CTRL_RST = 16'h0000;
    localparam logic [15:0] CMPE_CTRL_WMASK = 16'hE2D3;
    localparam logic [1:0] CMPE_EDGE_NONE = 2'h0;
    localparam logic [1:0] CMPE_EDGE_RISE = 2'h1;
    localparam logic [1:0] CMPE_EDGE_FALL = 2'h2;
    localparam logic [1:0] CMPE_EDGE_ANY = 2'h3;
endpackage

// ---- logic/cmpe_sync2.sv ----
// two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module cmpe_sync2 (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_d,
    output logic o_q
);
    logic meta;
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta <= 1'b0;
            o_q <= 1'b0;
        end
        else
        begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- logic/cmpe_top.sv ----
// control and event logic for three analog comparators
//
// Contract
// - three comparators, each with its own control register
// - result-to-pin bit drives raw, unsynchronised result onto the result pin
// - invert bit 13 inverts the comparator result before further use
// - polarity-adjusted result readable at bit 8, hardware updated
// - event flag bit 9 set by hardware, blocks further events until cleared
// - edge select bits 7-6: 11 any, 10 fall, 01 rise, 00 none
// - first event after nonzero edge select fires on any transition
// - reference bit 4 one selects internal reference voltage as noninverting input
// - reference bit zero selects first external input pin
// - unimplemented bits 12-10, 5, 3-2 read as zero
// - shared status register reports all results and event flags
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cmpe_top
    import cmpe_pkg::*;
#(
    parameter int N = cmpe_pkg::CMPE_N
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [cmpe_pkg::CMPE_AW-1:0] i_addr,
    input wire logic [cmpe_pkg::CMPE_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [cmpe_pkg::CMPE_DW-1:0] o_rdata,
    input wire logic [N-1:0] i_cmp_raw,
    output logic [N-1:0] o_comparator_on,
    output logic [N-1:0] o_noninv_source_select,
    output logic [1:0] o_inverting_channel_select [N],
    output logic [N-1:0] o_result_pin,
    output logic [N-1:0] o_result_pin_oe,
    output logic [N-1:0] o_trigger,
    output logic o_irq
);
    import cmpe_pkg::*;

    logic [15:0] ctrl [N];
    logic [N-1:0] event_flag;
    logic [N-1:0] res_sync;
    logic [N-1:0] res_prev;
    logic [N-1:0] armed;
    logic [N-1:0] trig;
    logic [N-1:0] irq_stat;
    logic [N-1:0] irq_mask;
    logic [N-1:0] result_bit;
    logic [N-1:0] ctrl_wr;
    logic [15:0] ctrl_rd [N];
    logic [15:0] shared_status;
    logic [15:0] next_rdata;
    wire sel_stat = (i_addr == CMPE_OFF_STAT);
    wire sel_istat = (i_addr == CMPE_OFF_IRQ_STAT);
    wire sel_imask = (i_addr == CMPE_OFF_IRQ_MASK);

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : gen_cmp
            wire [1:0] edge_sel = ctrl[g][CMPE_B_EDGE_HI:CMPE_B_EDGE_LO];
            wire rise = res_sync[g] & ~res_prev[g];
            wire fall = ~res_sync[g] & res_prev[g];
            wire any_chg = rise | fall;
            wire sel_hit = (edge_sel == CMPE_EDGE_ANY) ? any_chg :
                (edge_sel == CMPE_EDGE_FALL) ? fall :
                (edge_sel == CMPE_EDGE_RISE) ? rise : 1'b0;
            wire qualify = armed[g] ? sel_hit : any_chg;
            wire edge_on = (edge_sel != CMPE_EDGE_NONE) & ctrl[g][CMPE_B_ON];
            wire clr_evt = ctrl_wr[g] & ~i_wdata[CMPE_B_EVT];
            wire set_evt = edge_on & qualify & ~event_flag[g];

            assign ctrl_wr[g] = i_wr & (i_addr == 4'(g));
            assign trig[g] = set_evt;
            assign o_comparator_on[g] = ctrl[g][CMPE_B_ON];
            assign o_noninv_source_select[g] = ctrl[g][CMPE_B_REF];
            assign o_inverting_channel_select[g] = ctrl[g][CMPE_B_CH_HI:CMPE_B_CH_LO];
            // raw path, polarity applied, no clock involved
            assign o_result_pin[g] = (i_cmp_raw[g] ^ ctrl[g][CMPE_B_INV])
                & ctrl[g][CMPE_B_ON];
            assign o_result_pin_oe[g] = ctrl[g][CMPE_B_TOPIN] & ctrl[g][CMPE_B_ON];
            assign ctrl_rd[g] = (ctrl[g] & CMPE_CTRL_WMASK & ~(16'h1 << CMPE_B_EVT))
                | (16'(event_flag[g]) << CMPE_B_EVT)
                | (16'(result_bit[g]) << CMPE_B_RES);

            cmpe_sync2 u_sync (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(i_rst_n),
                .i_d(i_cmp_raw[g] ^ ctrl[g][CMPE_B_INV]),
                .o_q(res_sync[g])
            );

            always_ff @(posedge i_clk_sys or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    ctrl[g] <= CMPE_CTRL_RST;
                    event_flag[g] <= 1'b0;
                    res_prev[g] <= 1'b0;
                    armed[g] <= 1'b0;
                end
                else
                begin
                    if (ctrl_wr[g])
                        ctrl[g] <= i_wdata & CMPE_CTRL_WMASK;
                    res_prev[g] <= res_sync[g];
                    if (set_evt)
                        event_flag[g] <= 1'b1;
                    else if (clr_evt)
                        event_flag[g] <= 1'b0;
                    else if (ctrl_wr[g] & i_wdata[CMPE_B_EVT])
                        event_flag[g] <= 1'b1;
                    if (!edge_on)
                        armed[g] <= 1'b0;
                    else if (set_evt)
                        armed[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // result bit is zero while a comparator is off
    assign result_bit = res_sync & o_comparator_on;
    assign o_trigger = trig;
    assign o_irq = |(irq_stat & irq_mask);
    assign shared_status = (16'(event_flag) << CMPE_B_STAT_EVT)
        | (16'(result_bit) << CMPE_B_STAT_RES);

    always_comb
    begin
        next_rdata = 16'h0000;
        if (i_addr < 4'(N))
            next_rdata = ctrl_rd[i_addr[1:0]];
        else if (sel_stat)
            next_rdata = shared_status;
        else if (sel_istat)
            next_rdata = 16'(irq_stat);
        else if (sel_imask)
            next_rdata = 16'(irq_mask);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 16'h0000;
            irq_stat <= '0;
            irq_mask <= '0;
        end
        else
        begin
            o_rdata <= i_rd ? next_rdata : 16'h0000;
            irq_stat <= trig | (irq_stat & ~((i_wr & sel_istat) ? i_wdata[N-1:0] : '0));
            if (i_wr & sel_imask)
                irq_mask <= i_wdata[N-1:0];
        end
    end
endmodule
`default_nettype wire

// ---- testbench/cmpe_analog_model.sv ----
// behavioural model of the three analog comparators
`timescale 1ns/100ps
`default_nettype none
module cmpe_analog_model (
    input wire logic [2:0] i_on,
    input wire logic [2:0] i_ref_sel,
    input wire logic [2:0] i_ext_hi,
    input wire logic [2:0] i_ref_hi,
    output logic [2:0] o_raw
);
    // output low while powered down
    assign o_raw = i_on & ((i_ref_sel & i_ref_hi) | (~i_ref_sel & i_ext_hi));
endmodule
`default_nettype wire

// ---- testbench/cmpe_monitor.sv ----
// checker for the comparator event control block
`timescale 1ns/100ps
`default_nettype none
module cmpe_monitor #(
    parameter int N = 3
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [N-1:0] o_comparator_on,
    input wire logic [N-1:0] o_noninv_source_select,
    input wire logic [N-1:0] o_result_pin,
    input wire logic [N-1:0] o_result_pin_oe,
    input wire logic [N-1:0] o_trigger
);
    logic [N-1:0] blocked;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // event flag seen set until software writes it clear
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            blocked <= '0;
        else
            for (int k = 0; k < N; k++)
                if (o_trigger[k] || (i_wr && i_addr == 4'(k) && i_wdata[9]))
                    blocked[k] <= 1'b1;
                else if (i_wr && i_addr == 4'(k) && !i_wdata[9])
                    blocked[k] <= 1'b0;
    end
    a_unimpl_zero: assert property ($past(i_rd && i_addr < 4'h3) |-> (o_rdata & 16'h1C2C) == 0)
        else $error("unimplemented control bits read nonzero");
    a_pin_oe_on: assert property ((o_result_pin_oe & ~o_comparator_on) == '0)
        else $error("pin driven while comparator off");
    a_pin_off_low: assert property ((o_result_pin & ~o_comparator_on) == '0)
        else $error("result pin high while comparator off");
    a_trig_single: assert property ((o_trigger & $past(o_trigger)) == '0)
        else $error("trigger longer than one cycle");
    a_trig_blocked: assert property ((o_trigger & blocked) == '0)
        else $error("trigger while event flag set");
    a_wr_on_bit: assert property (i_wr && i_addr < 4'h3 |=>
        o_comparator_on[$past(i_addr)] == $past(i_wdata[15])) else $error("enable not taken");
    a_wr_ref_bit: assert property (i_wr && i_addr < 4'h3 |=>
        o_noninv_source_select[$past(i_addr)] == $past(i_wdata[4])) else $error("ref not taken");
    a_rd_on_bit: assert property ($past(i_rd && i_addr < 4'h3) |->
        o_rdata[15] == $past(o_comparator_on[i_addr])) else $error("enable readback wrong");
    c_trig: cover property (|o_trigger);
    c_pin: cover property (|o_result_pin_oe);
    c_read: cover property ($past(i_rd) && o_rdata[15]);
endmodule
bind cmpe_top cmpe_monitor #(.N(N)) cmpe_monitor_i (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_comparator_on, .o_noninv_source_select, .o_result_pin,
    .o_result_pin_oe, .o_trigger);
`default_nettype wire

// ---- testbench/tb.sv ----
// register-level testbench for the comparator event control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import cmpe_pkg::*;
    logic i_clk_sys = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, o_irq;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata;
    logic [2:0] i_cmp_raw, on, ns, pin, oe, trig, ext_hi = 3'h0, ref_hi = 3'h0;
    logic [1:0] chs [3];
    logic [15:0] tcnt [3];
    // step table: expected count, ext level, control word
    logic [23:0] st [9] = '{24'h018000, 24'h108040, 24'h2180C0, 24'h3080C0, 24'h318080,
        24'h408080, 24'h518040, 24'h508040, 24'h518000};
    int fails = 0, checks = 0;
    always #25 i_clk_sys = ~i_clk_sys;
    cmpe_top cmpe_top_i (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_cmp_raw, .o_comparator_on(on), .o_noninv_source_select(ns),
        .o_inverting_channel_select(chs), .o_result_pin(pin), .o_result_pin_oe(oe),
        .o_trigger(trig), .o_irq);
    cmpe_analog_model cmpe_analog_model_i (.i_on(on), .i_ref_sel(ns), .i_ext_hi(ext_hi),
        .i_ref_hi(ref_hi), .o_raw(i_cmp_raw));
    always_ff @(posedge i_clk_sys)
        for (int k = 0; k < 3; k++)
            tcnt[k] <= i_rst_n ? tcnt[k] + 16'(trig[k]) : 16'h0000;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        repeat (6) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 4; k++)
            rd(4'(k), 16'h0000);
        ext_hi[0] <= 1'b1;
        wr(CMPE_OFF_CTRL0, 16'hFC3F);
        repeat (4) @(posedge i_clk_sys);
        rd(CMPE_OFF_CTRL0, 16'hE113);
        rd(4'hF, 16'h0000);
        chk({4'h0, oe, pin, ns, on}, 16'h0249);
        chk({14'h0, chs[0]}, 16'h0003);
        ref_hi[0] <= 1'b1;
        #1;
        chk({13'h0, pin}, 16'h0000);
        ref_hi[0] <= 1'b0;
        $display("test control done");
        foreach (st[s])
        begin
            wr(CMPE_OFF_CTRL2, st[s][15:0]);
            ext_hi[2] <= st[s][16];
            repeat (8) @(posedge i_clk_sys);
            chk(tcnt[2], {12'h000, st[s][23:20]});
        end
        $display("test edges done");
        wr(CMPE_OFF_IRQ_MASK, 16'h0002);
        wr(CMPE_OFF_CTRL1, 16'h8040);
        for (int k = 0; k < 3; k++)
        begin
            ext_hi[1] <= ~ext_hi[1];
            repeat (8) @(posedge i_clk_sys);
        end
        chk(tcnt[1], 16'h0001);
        rd(CMPE_OFF_CTRL1, 16'h8340);
        rd(CMPE_OFF_STAT, 16'h0207);
        rd(CMPE_OFF_IRQ_STAT, 16'h0006);
        chk({15'h0, o_irq}, 16'h0001);
        wr(CMPE_OFF_IRQ_STAT, 16'h0002);
        rd(CMPE_OFF_IRQ_STAT, 16'h0004);
        chk({15'h0, o_irq}, 16'h0000);
        $display("test events done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
